// >>> rtl/uart_cs_defines.svh
`ifndef UART_CS_DEFINES_SVH
`define UART_CS_DEFINES_SVH
// register addresses and page
`define SCS_ADDR 8'h98
`define SDB_ADDR 8'h99
`define SFR_PAGE0 4'h0
// control/status field positions
`define B_MODE 7
`define B_ONE 6
`define B_MCE 5
`define B_REN 4
`define B_TB8 3
`define B_RB8 2
`define B_TI 1
`define B_RI 0
`define SCS_RESET 8'h40
// fifo geometry
`define TXF_W 8
`define TXF_D 8
`endif

// >>> rtl/uart_cs_pkg.sv
package uart_cs_pkg;
    // serial frame states, one-hot
    typedef enum logic [4:0] {
        S_IDLE = 5'b0_0001,
        S_START = 5'b0_0010,
        S_DATA = 5'b0_0100,
        S_NINTH = 5'b0_1000,
        S_STOP = 5'b1_0000
    } frame_st_t;
endpackage : uart_cs_pkg

// >>> rtl/uart_control_status.sv
//
// Summary of operation
// - mode bit 7 selects 8 or 9-bit frames
// - bit 6 reads one, writes ignored
// - 8-bit filter: receive needs stop bit one
// - 9-bit filter: receive needs ninth bit one
// - reception starts only while receive enable set
// - 9-bit mode sends tx ninth bit field
// - rx ninth bit gets stop or ninth
// - tx done set at stop bit start
// - rx done set at stop sampling
// - interrupt request when enabled and flag set
// - flags cleared only by software writes
// - control register bit-addressable at 0x98 page 0
// - 8-bit frame: start, 8 data lsb-first, stop
// - 9-bit frame adds ninth bit before stop
// - load only when rx done clear, filter passes
// - data write starts transmit, read gives latch
`timescale 1ns/1ps
`include "uart_cs_defines.svh"

// ----------------------------------------
// transmit fifo
// ----------------------------------------
module tx_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];  // storage
    logic [AW-1:0] wp_r, rp_r;  // pointers
    logic [AW:0] cnt_r;  // fill level
    logic push, pop;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = (cnt_r != (AW+1)'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rp_r];
    // write side
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end
    // pointers and level
    always_ff @(posedge clk) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wp_r <= wp_r + 1'b1;
            if (pop) rp_r <= rp_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : tx_fifo

// ----------------------------------------
// control, status and serial engines
// ----------------------------------------
module uart_control_status (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [3:0] sfr_page,
    input wire logic sfr_wr,
    input wire logic sfr_bit_wr,
    input wire logic [2:0] sfr_bit_sel,
    input wire logic sfr_bit_val,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic serial_irq_enable,
    output logic irq_req,
    output logic tx_buffer_ready,
    input wire logic baud_tick,
    input wire logic rxd,
    output logic txd
);
    import uart_cs_pkg::*;
    // control fields
    logic mode_r, mce_r, ren_r, tb8_r, rb8_r, ti_r, ri_r;
    logic [7:0] rx_latch_r;  // receive latch
    logic [7:0] rdata_r;
    logic irq_r, txd_r, txrdy_r;
    logic scs_sel, sdb_sel, byte_wr;
    logic [7:0] ctl_nxt;  // merged write image
    logic [7:0] ctl_now;  // current image
    // ----------------------------------------
    // register access
    // ----------------------------------------
    assign scs_sel = (sfr_page == `SFR_PAGE0) && (sfr_addr == `SCS_ADDR);
    assign sdb_sel = (sfr_page == `SFR_PAGE0) && (sfr_addr == `SDB_ADDR);
    assign byte_wr = sfr_wr && scs_sel;
    assign ctl_now = {mode_r, 1'b1, mce_r, ren_r, tb8_r, rb8_r, ti_r, ri_r};
    // byte write or single-bit write image
    always_comb begin
        ctl_nxt = ctl_now;
        if (byte_wr) begin
            ctl_nxt = sfr_wdata;
        end else if (sfr_bit_wr && scs_sel) begin
            ctl_nxt[sfr_bit_sel] = sfr_bit_val;
        end
    end
    // software-owned fields
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_r <= 1'b0;
            mce_r <= 1'b0;
            ren_r <= 1'b0;
            tb8_r <= 1'b0;
        end else begin
            mode_r <= ctl_nxt[`B_MODE];
            mce_r <= ctl_nxt[`B_MCE];
            ren_r <= ctl_nxt[`B_REN];
            tb8_r <= ctl_nxt[`B_TB8];
        end
    end
    // read mux, registered
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (sfr_rd) begin
            if (scs_sel) begin
                rdata_r <= ctl_now;
            end else if (sdb_sel) begin
                rdata_r <= rx_latch_r;
            end else begin
                rdata_r <= 8'h00;  // unmapped
            end
        end
    end
    assign sfr_rdata = rdata_r;
    // ----------------------------------------
    // transmit path
    // ----------------------------------------
    logic f_valid, f_ready, f_in_ready;
    logic [7:0] f_data;
    frame_st_t tx_st_r;
    logic tx_ph_r;  // half-bit phase
    logic [2:0] tx_cnt_r;
    logic [7:0] tx_sh_r;  // shift register
    logic tx_edge, tx_set;
    tx_fifo #(.W(`TXF_W), .D(`TXF_D)) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(sfr_wr && sdb_sel),
        .in_ready(f_in_ready),
        .in_data(sfr_wdata),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );
    assign f_ready = (tx_st_r == S_IDLE) && baud_tick;  // start on a tick: full start bit
    assign tx_edge = baud_tick && tx_ph_r;
    assign tx_set = tx_edge && (tx_st_r == S_DATA) && (tx_cnt_r == 3'd7) && !mode_r
        || tx_edge && (tx_st_r == S_NINTH);
    // half-bit phase from ticks
    always_ff @(posedge clk) begin
        if (rst || tx_st_r == S_IDLE) begin
            tx_ph_r <= 1'b0;
        end else if (baud_tick) begin
            tx_ph_r <= !tx_ph_r;
        end
    end
    // frame sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_st_r <= S_IDLE;
            tx_cnt_r <= 3'd0;
            tx_sh_r <= 8'h00;
            txd_r <= 1'b1;
        end else begin
            case (tx_st_r)
                S_IDLE: begin
                    txd_r <= 1'b1;
                    if (f_valid && f_ready) begin
                        tx_sh_r <= f_data;
                        txd_r <= 1'b0;
                        tx_st_r <= S_START;
                    end
                end
                S_START: begin
                    if (tx_edge) begin
                        txd_r <= tx_sh_r[0];
                        tx_sh_r <= tx_sh_r >> 1;
                        tx_cnt_r <= 3'd0;
                        tx_st_r <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (tx_edge) begin
                        if (tx_cnt_r != 3'd7) begin
                            txd_r <= tx_sh_r[0];
                            tx_sh_r <= tx_sh_r >> 1;
                            tx_cnt_r <= tx_cnt_r + 3'd1;
                        end else if (mode_r) begin
                            txd_r <= tb8_r;
                            tx_st_r <= S_NINTH;
                        end else begin
                            txd_r <= 1'b1;
                            tx_st_r <= S_STOP;
                        end
                    end
                end
                S_NINTH: begin
                    if (tx_edge) begin
                        txd_r <= 1'b1;
                        tx_st_r <= S_STOP;
                    end
                end
                default: begin
                    if (tx_edge) begin
                        tx_st_r <= S_IDLE;
                    end
                end
            endcase
        end
    end
    // ----------------------------------------
    // receive path
    // ----------------------------------------
    frame_st_t rx_st_r;
    logic rx_ph_r, rx_prev_r, rx_samp;
    logic [2:0] rx_cnt_r;
    logic [7:0] rx_sh_r;
    logic rx_nin_r, rx_take, rx_pass;
    assign rx_samp = baud_tick && !rx_ph_r;  // mid-bit point
    assign rx_pass = !ri_r && (!mce_r || (mode_r ? rx_nin_r : rxd));
    assign rx_take = rx_samp && (rx_st_r == S_STOP) && rx_pass;
    // line history
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_prev_r <= 1'b1;
        end else begin
            rx_prev_r <= rxd;
        end
    end
    // phase restarts on start edge
    always_ff @(posedge clk) begin
        if (rst || rx_st_r == S_IDLE) begin
            rx_ph_r <= 1'b0;
        end else if (baud_tick) begin
            rx_ph_r <= !rx_ph_r;
        end
    end
    // receive sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_st_r <= S_IDLE;
            rx_cnt_r <= 3'd0;
            rx_sh_r <= 8'h00;
            rx_nin_r <= 1'b0;
        end else begin
            case (rx_st_r)
                S_IDLE: begin
                    if (ren_r && rx_prev_r && !rxd) begin
                        rx_st_r <= S_START;
                    end
                end
                S_START: begin
                    if (rx_samp) begin
                        rx_cnt_r <= 3'd0;
                        rx_st_r <= rxd ? S_IDLE : S_DATA;  // false start
                    end
                end
                S_DATA: begin
                    if (rx_samp) begin
                        rx_sh_r <= {rxd, rx_sh_r[7:1]};
                        rx_cnt_r <= rx_cnt_r + 3'd1;
                        if (rx_cnt_r == 3'd7) begin
                            rx_st_r <= mode_r ? S_NINTH : S_STOP;
                        end
                    end
                end
                S_NINTH: begin
                    if (rx_samp) begin
                        rx_nin_r <= rxd;
                        rx_st_r <= S_STOP;
                    end
                end
                default: begin
                    if (rx_samp) begin
                        rx_st_r <= S_IDLE;
                    end
                end
            endcase
        end
    end
    // receive latch and ninth bit
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_latch_r <= 8'h00;
            rb8_r <= 1'b0;
        end else if (rx_take) begin
            rx_latch_r <= rx_sh_r;
            rb8_r <= mode_r ? rx_nin_r : rxd;
        end else begin
            rb8_r <= ctl_nxt[`B_RB8];
        end
    end
    // ----------------------------------------
    // flags and interrupt request
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ti_r <= 1'b0;
            ri_r <= 1'b0;
        end else begin
            ti_r <= tx_set | ctl_nxt[`B_TI];
            ri_r <= rx_take | ctl_nxt[`B_RI];
        end
    end
    // registered outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_r <= 1'b0;
            txrdy_r <= 1'b0;
        end else begin
            irq_r <= serial_irq_enable && (ti_r || ri_r);
            txrdy_r <= f_in_ready;
        end
    end
    assign irq_req = irq_r;
    assign txd = txd_r;
    assign tx_buffer_ready = txrdy_r;
    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_RI_FILTER: assert property (@(posedge clk) disable iff (rst)
        rx_samp && rx_st_r == S_STOP && mce_r && !mode_r && !rxd |=> !$rose(ri_r))
        else $error("ri set on bad stop bit");
    AST_RI_NINTH: assert property (@(posedge clk) disable iff (rst)
        rx_samp && rx_st_r == S_STOP && mce_r && mode_r && !rx_nin_r |=> $stable(rx_latch_r))
        else $error("latch loaded on data byte");
    AST_REN: assert property (@(posedge clk) disable iff (rst)
        rx_st_r == S_IDLE && !ren_r |=> rx_st_r == S_IDLE)
        else $error("receive while disabled");
    AST_ONE: assert property (@(posedge clk) disable iff (rst)
        sfr_rd && scs_sel |=> sfr_rdata[`B_ONE])
        else $error("bit 6 not one");
    AST_TI_SET: assert property (@(posedge clk) disable iff (rst)
        tx_set |=> ti_r)
        else $error("tx done not set");
    AST_RI_SET: assert property (@(posedge clk) disable iff (rst)
        rx_take |=> ri_r && rx_latch_r == $past(rx_sh_r))
        else $error("rx done not set");
    AST_HOLD: assert property (@(posedge clk) disable iff (rst)
        ri_r && !byte_wr && !sfr_bit_wr |=> ri_r)
        else $error("rx done cleared by hardware");
    AST_IRQ: assert property (@(posedge clk) disable iff (rst)
        serial_irq_enable && ti_r |=> irq_req)
        else $error("no interrupt request");
    AST_STOP_LVL: assert property (@(posedge clk) disable iff (rst)
        tx_st_r == S_STOP |-> txd)
        else $error("stop bit low");
    COV_TX: cover property (@(posedge clk) tx_set);
    COV_RX: cover property (@(posedge clk) rx_take && mode_r);
    COV_FULL: cover property (@(posedge clk) !f_in_ready);
endmodule : uart_control_status

// >>> verification/serial_node.sv
`timescale 1ns/1ps
// ----------------------------------------
// remote serial node model
// ----------------------------------------
module serial_node (
    input wire logic clk,
    input wire logic baud_tick,
    input wire logic nine,
    input wire logic txd,
    output logic rxd
);
    logic [7:0] got [0:15]; // bytes seen on txd
    logic got_b9; // last ninth bit
    logic got_stop; // last stop bit
    int got_n = 0; // frames seen
    initial rxd = 1'b1; // idle line high

    // send one frame, two ticks per bit, lsb first
    task automatic send(input logic [7:0] d, input logic md, input logic b9,
                        input logic sb);
        logic [10:0] f;
        f = md ? {sb, b9, d, 1'b0} : {1'b1, sb, d, 1'b0};
        @(posedge clk iff baud_tick);
        for (int i = 0; i < (md ? 11 : 10); i++) begin
            rxd <= f[i];
            repeat (2) @(posedge clk iff baud_tick);
        end
        rxd <= 1'b1; // release to idle
    endtask : send

    // capture frames, sampling on odd ticks (mid bit)
    initial forever begin
        @(negedge clk iff txd === 1'b0);
        @(posedge clk iff baud_tick);
        for (int i = 0; i < 8; i++) begin
            repeat (2) @(posedge clk iff baud_tick);
            got[got_n[3:0]][i] = txd;
        end
        if (nine) begin
            repeat (2) @(posedge clk iff baud_tick);
            got_b9 = txd;
        end
        repeat (2) @(posedge clk iff baud_tick);
        got_stop = txd;
        got_n++;
    end
endmodule : serial_node

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    // ----------------------------------------
    // stimulus and wiring
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic [3:0] sfr_page = 4'h0; // register page select
    logic sfr_wr = 1'b0;
    logic sfr_bit_wr = 1'b0;
    logic [2:0] sfr_bit_sel = 3'h0;
    logic sfr_bit_val = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_rdata;
    logic irq_en = 1'b1; // interrupt enable level
    logic irq_req;
    logic tx_buffer_ready;
    logic txd;
    logic rxd;
    logic baud_tick = 1'b0;
    logic nine = 1'b0; // frame length seen by monitor
    logic [1:0] tick_div = 2'h0;
    logic [5:0] c; // rx case: mode mce ren b9 stop preset
    logic ld; // frame should be latched
    logic [7:0] exp_d = 8'h00; // expected receive latch
    int fail_count = 0;
    int compares = 0;

    always #4 clk = ~clk;
    // tick every fourth clock
    always @(posedge clk) begin
        tick_div <= tick_div + 2'h1;
        baud_tick <= (tick_div == 2'h3);
    end

    uart_control_status uut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_page(sfr_page),
        .sfr_wr(sfr_wr), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel),
        .sfr_bit_val(sfr_bit_val), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .serial_irq_enable(irq_en), .irq_req(irq_req),
        .tx_buffer_ready(tx_buffer_ready), .baud_tick(baud_tick), .rxd(rxd), .txd(txd));
    serial_node node (.clk(clk), .baud_tick(baud_tick), .nine(nine), .txd(txd), .rxd(rxd));

    // ----------------------------------------
    // bus tasks and compare
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask : wr
    task automatic bwr(input logic [2:0] b, input logic val);
        @(posedge clk);
        sfr_addr <= 8'h98;
        sfr_bit_sel <= b;
        sfr_bit_val <= val;
        sfr_bit_wr <= 1'b1;
        @(posedge clk);
        sfr_bit_wr <= 1'b0;
    endtask : bwr
    // read then compare, data settles one cycle after strobe
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 chk(sfr_rdata, exp);
    endtask : rchk
    // bounded wait for captured frame count
    task automatic wait_tx(input int n);
        for (int k = 0; k < 3000 && node.got_n < n; k++) @(posedge clk);
        chk(8'(node.got_n), 8'(n));
    endtask : wait_tx
    task automatic test_done;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    // watchdog against hangs
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        test_done();
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rchk(8'h98, 8'h40);
        chk({6'h0, irq_req, txd}, 8'h01);
        wr(8'h98, 8'h3C);
        rchk(8'h98, 8'h7C);
        wr(8'h98, 8'h00);
        bwr(3'd6, 1'b0);
        rchk(8'h98, 8'h40);
        bwr(3'd5, 1'b1);
        rchk(8'h98, 8'h60);
        bwr(3'd1, 1'b1);
        rchk(8'h98, 8'h62);
        chk({7'h0, irq_req}, 8'h01);
        irq_en <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk({7'h0, irq_req}, 8'h00);
        irq_en <= 1'b1;
        repeat (20) @(posedge clk);
        rchk(8'h98, 8'h62);
        bwr(3'd1, 1'b0);
        rchk(8'h98, 8'h60);
        rchk(8'h97, 8'h00);
        // write on another page must not reach the control byte
        sfr_page <= 4'h1;
        wr(8'h98, 8'hFF);
        sfr_page <= 4'h0;
        rchk(8'h98, 8'h60);
        // 8-bit send, ninth field set but unused
        wr(8'h98, 8'h08);
        wr(8'h99, 8'hA5);
        rchk(8'h98, 8'h48);
        wait_tx(1);
        chk(node.got[0], 8'hA5);
        chk({7'h0, node.got_stop}, 8'h01);
        rchk(8'h98, 8'h4A);
        // 9-bit send, both ninth bit values
        for (int b = 0; b < 2; b++) begin
            wr(8'h98, 8'h80 | 8'(b << 3));
            nine <= 1'b1;
            wr(8'h99, 8'h3C + 8'(b));
            wait_tx(2 + b);
            chk(node.got[1 + b], 8'h3C + 8'(b));
            chk({7'h0, node.got_b9}, 8'(b));
            rchk(8'h98, 8'hC2 | 8'(b << 3));
        end
        // fill fifo until it refuses, then drain
        wr(8'h98, 8'h00);
        nine <= 1'b0;
        for (int i = 0; i < 10; i++) wr(8'h99, 8'h10 + 8'(i));
        #1 chk({7'h0, tx_buffer_ready}, 8'h00);
        wait_tx(12);
        repeat (300) @(posedge clk);
        chk(8'(node.got_n), 8'd12);
        for (int i = 0; i < 9; i++) chk(node.got[3 + i], 8'h10 + 8'(i));
        chk({7'h0, tx_buffer_ready}, 8'h01);
        // receive cases, expectation from filter rules
        for (int i = 0; i < 8; i++) begin
            case (i)
                0: c = 6'b001000;
                1: c = 6'b011000;
                2: c = 6'b011010;
                3: c = 6'b111010;
                4: c = 6'b111110;
                5: c = 6'b101100;
                6: c = 6'b000010;
                default: c = 6'b001011;
            endcase
            ld = c[3] && !c[0] && (!c[4] || (c[5] ? c[2] : c[1]));
            wr(8'h98, {c[5], 1'b0, c[4], c[3], 3'b000, c[0]});
            node.send(8'hC3 ^ 8'(i), c[5], c[2], c[1]);
            repeat (4) @(posedge clk);
            if (ld) exp_d = 8'hC3 ^ 8'(i);
            rchk(8'h98, {c[5], 1'b1, c[4], c[3], 1'b0,
                ld & (c[5] ? c[2] : c[1]), 1'b0, ld | c[0]});
            rchk(8'h99, exp_d);
            chk({7'h0, irq_req}, {7'h0, ld | c[0]});
        end
        test_done();
    end
endmodule : tb_top
